/* File: src/sfd_cfg.svh */
// constants of the storage format decoder: widths, fields, opcodes
`ifndef SFD_CFG_SVH
`define SFD_CFG_SVH

// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define SFD_AW        24
`define SFD_GPR_W     32
`define SFD_CNT_W     9

// ---------------------------------------------------------------
// field positions, instruction bit 0 is INSTR[47]
// ---------------------------------------------------------------
`define SFD_F_OPC     47:40
`define SFD_F_BYTE1   39:32
`define SFD_F_B1      31:28
`define SFD_F_D1      27:16
`define SFD_F_B2      15:12
`define SFD_F_D2      11:0
`define SFD_F_L1      7:4
`define SFD_F_L2      3:0

// ---------------------------------------------------------------
// instruction lengths and counts
// ---------------------------------------------------------------
`define SFD_ILEN_SI   24'h000004
`define SFD_ILEN_SS   24'h000006
`define SFD_CNT_ONE   9'h001
`define SFD_CNT_ZERO  9'h000
`define SFD_CNT_MAX1  9'h100
`define SFD_CNT_MAX2  9'h010

// ---------------------------------------------------------------
// opcodes; values are arbitrary
// ---------------------------------------------------------------
`define OPC_IMMEDIATE_ADD       8'h40
`define OPC_IMMEDIATE_CMP_LOG   8'h41
`define OPC_IMMEDIATE_MOVE      8'h42
`define OPC_IMMEDIATE_AND       8'h43
`define OPC_IMMEDIATE_OR        8'h44
`define OPC_MASK_TEST           8'h45
`define OPC_IMMEDIATE_XOR       8'h46
`define OPC_HALT_PROCEED        8'h48
`define OPC_STATE_WORD_LOAD     8'h49
`define OPC_SYSTEM_MASK_SET     8'h4a
`define OPC_IO_START            8'h4c
`define OPC_CHAR_CMP_LOG        8'h60
`define OPC_PATTERN_FORMAT_OP   8'h61
`define OPC_CHAR_MOVE           8'h62
`define OPC_LOW_NIBBLE_MOVE     8'h63
`define OPC_HIGH_NIBBLE_MOVE    8'h64
`define OPC_CHAR_AND_OP         8'h65
`define OPC_CHAR_OR_OP          8'h66
`define OPC_BYTE_TABLE_LOOKUP   8'h67
`define OPC_CHAR_XOR_OP         8'h68
`define OPC_DECIMAL_ADD         8'h70
`define OPC_DECIMAL_COMPARE     8'h71
`define OPC_DECIMAL_DIVIDE      8'h72
`define OPC_DECIMAL_MULTIPLY    8'h73
`define OPC_NIBBLE_SHIFT_MOVE   8'h74
`define OPC_DECIMAL_PACK        8'h75
`define OPC_DECIMAL_MINUS       8'h76
`define OPC_DECIMAL_EXPAND      8'h77
`define OPC_DECIMAL_ZERO_ADD    8'h78

`endif

/* File: src/sfd_pkg.sv */
// types of the storage format decoder
`include "sfd_cfg.svh"

package sfd_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BASE = 2'b10
    } sfd_state_t;

    typedef enum logic [1:0] {
        FMT_NONE = 2'h0,
        FMT_SI   = 2'h1,
        FMT_SS1  = 2'h2,
        FMT_SS2  = 2'h3
    } sfd_fmt_t;

    typedef enum logic [2:0] {
        CAT_NONE     = 3'h0,
        CAT_LOGICAL  = 3'h1,
        CAT_PROC_CTL = 3'h2,
        CAT_IO_CTL   = 3'h3,
        CAT_CHAR     = 3'h4,
        CAT_DECIMAL  = 3'h5
    } sfd_cat_t;

    typedef struct packed {
        sfd_fmt_t fmt;
        sfd_cat_t cat;
        logic     priv;
        logic     invalid;
    } sfd_class_t;

    typedef struct packed {
        sfd_class_t                cls;
        logic                      misaligned;
        logic [7:0]                opcode;
        logic [7:0]                immediate_byte;
        logic [`SFD_CNT_W-1:0]     op1_byte_count;
        logic [`SFD_CNT_W-1:0]     op2_byte_count;
        logic [`SFD_AW-1:0]        op1_ea;
        logic [`SFD_AW-1:0]        op2_ea;
        logic [`SFD_AW-1:0]        next_addr;
    } sfd_result_t;

    typedef struct packed {
        sfd_state_t                state;
        logic                      dec_valid;
        logic [7:0]                opc;
        logic [7:0]                byte1;
        logic [3:0]                op1_base_reg;
        logic [11:0]               op1_displacement;
        logic [3:0]                op2_base_reg;
        logic [11:0]               op2_displacement;
        logic [`SFD_AW-1:0]        ia;
        sfd_result_t               res;
    } sfd_regs_t;

endpackage

/* File: src/sfd_decoder.sv */
// storage format decoder: field split, class, effective addresses
`timescale 1ns/1ps
`include "sfd_cfg.svh"

// Summary of operation
// - immediate format is four bytes; next address is plus four
// - immediate group holds eleven ops in three categories
// - seven immediate arithmetic and logic ops decode as logical
// - halt, state load, mask set and io start are privileged
// - opcode 0-7, immediate 8-15, base 16-19, displacement 20-31
// - immediate byte goes out unchanged as operand 2
// - immediate format operand 1 address is base plus displacement
// - equal length format is six bytes with one shared length
// - equal length format operands reach at most 256 bytes
// - length field from bit 8 applies to both operands
// - base/displacement at 16-19/20-31 and 32-35/36-47
// - each storage operand address is own base plus displacement
// - equal length group decodes nine character operations
// - unequal length format is six bytes, two separate lengths
// - unequal length operands reach at most 16 bytes each
// - bits 8-11 give operand 1 length, 12-15 operand 2 length
// - unequal group decodes decimal ops, offset move, pack, unpack
// - instructions start on even addresses; odd ones flagged
module sfd_decoder
    import sfd_pkg::*;
(
    input  wire logic                  CLK,
    input  wire logic                  RST_N,
    input  wire logic                  INSTR_VALID,
    input  wire logic [47:0]           INSTR,
    input  wire logic [`SFD_AW-1:0]    INSTR_ADDR,
    output      logic                  INSTR_READY,
    output      logic [3:0]            OP1_BASE_REG,
    output      logic [3:0]            OP2_BASE_REG,
    input  wire logic [`SFD_GPR_W-1:0] BASE1_VAL,
    input  wire logic [`SFD_GPR_W-1:0] BASE2_VAL,
    output      logic                  DEC_VALID,
    output      sfd_result_t           DEC_RESULT
);

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    function automatic sfd_class_t sfd_decode(input logic [7:0] opc);
        sfd_class_t c;
        c = '{FMT_NONE, CAT_NONE, 1'b0, 1'b0};
        case (opc)
            // eleven immediate ops in three categories
            `OPC_IMMEDIATE_ADD,
            `OPC_IMMEDIATE_CMP_LOG,
            `OPC_IMMEDIATE_MOVE,
            `OPC_IMMEDIATE_AND,
            `OPC_IMMEDIATE_OR,
            `OPC_MASK_TEST,
            `OPC_IMMEDIATE_XOR:
                c = '{FMT_SI, CAT_LOGICAL, 1'b0, 1'b0};
            `OPC_HALT_PROCEED,
            `OPC_STATE_WORD_LOAD,
            `OPC_SYSTEM_MASK_SET:
                c = '{FMT_SI, CAT_PROC_CTL, 1'b1, 1'b0};
            `OPC_IO_START:
                c = '{FMT_SI, CAT_IO_CTL, 1'b1, 1'b0};
            // nine character ops, shared length
            `OPC_CHAR_CMP_LOG,
            `OPC_PATTERN_FORMAT_OP,
            `OPC_CHAR_MOVE,
            `OPC_LOW_NIBBLE_MOVE,
            `OPC_HIGH_NIBBLE_MOVE,
            `OPC_CHAR_AND_OP,
            `OPC_CHAR_OR_OP,
            `OPC_BYTE_TABLE_LOOKUP,
            `OPC_CHAR_XOR_OP:
                c = '{FMT_SS1, CAT_CHAR, 1'b0, 1'b0};
            // decimal and nibble ops, split lengths
            `OPC_DECIMAL_ADD,
            `OPC_DECIMAL_COMPARE,
            `OPC_DECIMAL_DIVIDE,
            `OPC_DECIMAL_MULTIPLY,
            `OPC_NIBBLE_SHIFT_MOVE,
            `OPC_DECIMAL_PACK,
            `OPC_DECIMAL_MINUS,
            `OPC_DECIMAL_EXPAND,
            `OPC_DECIMAL_ZERO_ADD:
                c = '{FMT_SS2, CAT_DECIMAL, 1'b0, 1'b0};
            default:
                c = '{FMT_NONE, CAT_NONE, 1'b0, 1'b1};
        endcase
        return c;
    endfunction

    // carry out of the top address bit is simply lost
    function automatic logic [`SFD_AW-1:0] sfd_ea(
        input logic [`SFD_GPR_W-1:0] base,
        input logic [11:0]           disp
    );
        logic [`SFD_GPR_W-1:0] sum;
        sum = base + {{(`SFD_GPR_W-12){1'b0}}, disp};
        return sum[`SFD_AW-1:0];
    endfunction

    // encoded length is count minus one
    function automatic logic [`SFD_CNT_W-1:0] sfd_count(
        input logic [7:0] len
    );
        return {1'b0, len} + `SFD_CNT_ONE;
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    sfd_regs_t  s_q;
    sfd_regs_t  s_d;
    sfd_class_t cls;
    logic       is_si;

    assign cls   = sfd_decode(s_q.opc);
    assign is_si = (cls.fmt == FMT_SI);

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        s_d           = s_q;
        s_d.dec_valid = 1'b0;
        unique case (s_q.state)
            ST_IDLE:
            begin
                if (INSTR_VALID)
                begin
                    s_d.opc              = INSTR[`SFD_F_OPC];
                    s_d.byte1            = INSTR[`SFD_F_BYTE1];
                    s_d.op1_base_reg     = INSTR[`SFD_F_B1];
                    s_d.op1_displacement = INSTR[`SFD_F_D1];
                    s_d.op2_base_reg     = INSTR[`SFD_F_B2];
                    s_d.op2_displacement = INSTR[`SFD_F_D2];
                    s_d.ia               = INSTR_ADDR;
                    s_d.state            = ST_BASE;
                end
            end
            ST_BASE:
            begin
                // base values are read while the selects stand
                s_d.res.cls        = cls;
                s_d.res.opcode     = s_q.opc;
                s_d.res.misaligned = s_q.ia[0];
                s_d.res.immediate_byte =
                    is_si ? s_q.byte1 : 8'h00;
                s_d.res.op1_ea = sfd_ea(BASE1_VAL,
                    s_q.op1_displacement);
                s_d.res.op2_ea = is_si ? '0 : sfd_ea(BASE2_VAL,
                    s_q.op2_displacement);
                unique case (cls.fmt)
                    FMT_SI:
                    begin
                        s_d.res.op1_byte_count = `SFD_CNT_ONE;
                        s_d.res.op2_byte_count = `SFD_CNT_ONE;
                        s_d.res.next_addr =
                            s_q.ia + `SFD_ILEN_SI;
                    end
                    FMT_SS1:
                    begin
                        s_d.res.op1_byte_count =
                            sfd_count(s_q.byte1);
                        s_d.res.op2_byte_count =
                            sfd_count(s_q.byte1);
                        s_d.res.next_addr =
                            s_q.ia + `SFD_ILEN_SS;
                    end
                    FMT_SS2:
                    begin
                        s_d.res.op1_byte_count = sfd_count(
                            {4'h0, s_q.byte1[`SFD_F_L1]});
                        s_d.res.op2_byte_count = sfd_count(
                            {4'h0, s_q.byte1[`SFD_F_L2]});
                        s_d.res.next_addr =
                            s_q.ia + `SFD_ILEN_SS;
                    end
                    FMT_NONE:
                    begin
                        // unknown length: fetch must not advance
                        s_d.res.op1_byte_count = `SFD_CNT_ZERO;
                        s_d.res.op2_byte_count = `SFD_CNT_ZERO;
                        s_d.res.next_addr      = s_q.ia;
                    end
                endcase
                s_d.dec_valid = 1'b1;
                s_d.state     = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            s_q       <= '0;
            s_q.state <= ST_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign INSTR_READY  = (s_q.state == ST_IDLE);
    assign OP1_BASE_REG = s_q.op1_base_reg;
    assign OP2_BASE_REG = s_q.op2_base_reg;
    assign DEC_VALID    = s_q.dec_valid;
    assign DEC_RESULT   = s_q.res;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_accept;
        INSTR_VALID && INSTR_READY;
    endsequence

    sequence s_result;
        DEC_VALID ##0 INSTR_READY;
    endsequence

    property p_walk;
        s_accept |=> !INSTR_READY && !DEC_VALID ##1 s_result;
    endproperty

    property p_imm;
        s_accept ##1 1'b1 |=> DEC_RESULT.cls.fmt != FMT_SI
            || DEC_RESULT.immediate_byte == $past(INSTR[`SFD_F_BYTE1], 2);
    endproperty

    property p_odd;
        s_accept ##0 INSTR_ADDR[0] |=> ##1 DEC_RESULT.misaligned;
    endproperty

    property p_ea;
        s_accept ##1 1'b1 |=> DEC_RESULT.op1_ea ==
            sfd_ea($past(BASE1_VAL), $past(INSTR[`SFD_F_D1], 2));
    endproperty

    // immediate format has no second storage operand
    property p_ea2;
        s_accept ##1 !is_si |=> DEC_RESULT.op2_ea ==
            sfd_ea($past(BASE2_VAL), $past(INSTR[`SFD_F_D2], 2));
    endproperty

    property p_sel;
        s_accept |=> OP1_BASE_REG == $past(INSTR[`SFD_F_B1])
            && OP2_BASE_REG == $past(INSTR[`SFD_F_B2]);
    endproperty

    property p_opc;
        s_accept ##1 1'b1 |=>
            DEC_RESULT.opcode == $past(INSTR[`SFD_F_OPC], 2);
    endproperty

    a_handshake_walk: assert property (p_walk)
        else $error("decode result not two cycles after accept");
    a_imm_pass: assert property (p_imm)
        else $error("immediate byte altered");
    a_odd_addr: assert property (p_odd)
        else $error("odd instruction address not flagged");
    a_ea_op1: assert property (p_ea)
        else $error("operand 1 address not base plus displacement");
    a_si_next: assert property (DEC_VALID && is_si |->
        DEC_RESULT.next_addr == s_q.ia + `SFD_ILEN_SI)
        else $error("immediate format did not advance by four");
    a_ss_next: assert property (DEC_VALID &&
        DEC_RESULT.cls.fmt inside {FMT_SS1, FMT_SS2} |->
        DEC_RESULT.next_addr == s_q.ia + `SFD_ILEN_SS)
        else $error("storage format did not advance by six");
    a_priv_cat: assert property (DEC_VALID && DEC_RESULT.cls.priv
        |-> is_si && DEC_RESULT.cls.cat != CAT_LOGICAL)
        else $error("privilege flag on a wrong opcode");
    a_logic_cat: assert property (DEC_VALID &&
        DEC_RESULT.cls.cat == CAT_LOGICAL |->
        !DEC_RESULT.cls.priv && is_si)
        else $error("logical op misclassified");
    a_ss1_count: assert property (DEC_VALID &&
        DEC_RESULT.cls.fmt == FMT_SS1 |->
        DEC_RESULT.op1_byte_count == DEC_RESULT.op2_byte_count &&
        DEC_RESULT.op1_byte_count <= `SFD_CNT_MAX1 &&
        DEC_RESULT.op1_byte_count == {1'b0, s_q.byte1} + `SFD_CNT_ONE)
        else $error("shared length wrong");
    a_ss2_count: assert property (DEC_VALID &&
        DEC_RESULT.cls.fmt == FMT_SS2 |->
        DEC_RESULT.op1_byte_count <= `SFD_CNT_MAX2 &&
        DEC_RESULT.op2_byte_count ==
        {5'h00, s_q.byte1[`SFD_F_L2]} + `SFD_CNT_ONE)
        else $error("split lengths wrong");
    a_invalid_hold: assert property (DEC_VALID &&
        DEC_RESULT.cls.invalid |-> !DEC_RESULT.cls.priv &&
        DEC_RESULT.next_addr == s_q.ia)
        else $error("invalid opcode advanced or privileged");
    a_base_select: assert property (p_sel)
        else $error("base register selects not taken from fields");
    a_opcode_pass: assert property (p_opc)
        else $error("opcode field altered");
    a_ea_op2: assert property (p_ea2)
        else $error("operand 2 address not base plus displacement");
    a_ss2_class: assert property (DEC_VALID &&
        DEC_RESULT.cls.fmt == FMT_SS2 |->
        DEC_RESULT.cls.cat == CAT_DECIMAL && !DEC_RESULT.cls.priv)
        else $error("unequal length op misclassified");

endmodule // sfd_decoder

/* File: dv/sfd_fetch_model.sv */
// register file side of the fetch unit, feeds base contents
`timescale 1ns/1ps
`include "sfd_cfg.svh"

module sfd_fetch_model
    import sfd_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  instr_ready,
    input  wire logic [3:0]            op1_base_reg,
    input  wire logic [3:0]            op2_base_reg,
    output      logic [`SFD_GPR_W-1:0] base1_val,
    output      logic [`SFD_GPR_W-1:0] base2_val
);
    // off the read cycle the bus carries a moving pattern, not old data
    logic [`SFD_GPR_W-1:0] junk_q = 32'ha5c3_5a3c;

    always @(posedge clk)
    begin
        junk_q <= ~junk_q + 32'h1;
    end

    // register n holds its number in every nibble; reg 15 forces wrap
    assign base1_val = instr_ready ? junk_q : {8{op1_base_reg}};
    assign base2_val = instr_ready ? ~junk_q : {8{op2_base_reg}};
endmodule // sfd_fetch_model

/* File: dv/sfd_decoder_test.sv */
// self-checking bench of the storage format decoder
`timescale 1ns/1ps
`include "sfd_cfg.svh"

module sfd_decoder_test
    import sfd_pkg::*;
;
    logic                  clk;
    logic                  rst_n;
    logic                  instr_valid;
    logic [47:0]           instr;
    logic [`SFD_AW-1:0]    instr_addr;
    logic                  instr_ready;
    logic [3:0]            op1_base_reg;
    logic [3:0]            op2_base_reg;
    logic [`SFD_GPR_W-1:0] base1_val;
    logic [`SFD_GPR_W-1:0] base2_val;
    logic                  dec_valid;
    sfd_result_t           dec_result;
    int                    errors;
    int                    cmp_count;

    sfd_decoder dut (.CLK(clk), .RST_N(rst_n), .INSTR_VALID(instr_valid),
        .INSTR(instr), .INSTR_ADDR(instr_addr), .INSTR_READY(instr_ready),
        .OP1_BASE_REG(op1_base_reg), .OP2_BASE_REG(op2_base_reg),
        .BASE1_VAL(base1_val), .BASE2_VAL(base2_val),
        .DEC_VALID(dec_valid), .DEC_RESULT(dec_result));

    sfd_fetch_model fetch (.clk(clk), .instr_ready(instr_ready),
        .op1_base_reg(op1_base_reg), .op2_base_reg(op2_base_reg),
        .base1_val(base1_val), .base2_val(base2_val));

    // ----
    // helpers
    // ----
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic sfd_result_t exp_of(input logic [47:0] ins,
                                           input logic [23:0] a);
        sfd_result_t r;
        logic [23:0] ea1;
        logic [23:0] ea2;
        r = '0;
        ea1 = {6{ins[31:28]}} + {12'h000, ins[27:16]};
        ea2 = {6{ins[15:12]}} + {12'h000, ins[11:0]};
        r.opcode = ins[47:40];
        r.misaligned = a[0];
        r.next_addr = a;
        case (ins[47:40]) inside
            [`OPC_IMMEDIATE_ADD:`OPC_IMMEDIATE_XOR]:
                r.cls = '{FMT_SI, CAT_LOGICAL, 1'b0, 1'b0};
            [`OPC_HALT_PROCEED:`OPC_SYSTEM_MASK_SET]:
                r.cls = '{FMT_SI, CAT_PROC_CTL, 1'b1, 1'b0};
            `OPC_IO_START:
                r.cls = '{FMT_SI, CAT_IO_CTL, 1'b1, 1'b0};
            [`OPC_CHAR_CMP_LOG:`OPC_CHAR_XOR_OP]:
                r.cls = '{FMT_SS1, CAT_CHAR, 1'b0, 1'b0};
            [`OPC_DECIMAL_ADD:`OPC_DECIMAL_ZERO_ADD]:
                r.cls = '{FMT_SS2, CAT_DECIMAL, 1'b0, 1'b0};
            default:
                r.cls.invalid = 1'b1;
        endcase
        if (r.cls.fmt == FMT_SI)
        begin
            r.immediate_byte = ins[39:32];
            r.op1_byte_count = 9'h001;
            r.op2_byte_count = 9'h001;
            r.op1_ea = ea1;
            r.next_addr = a + 24'h000004;
        end
        else if (r.cls.fmt != FMT_NONE)
        begin
            r.op1_byte_count = {1'b0, ins[39:32]} + 9'h001;
            r.op2_byte_count = r.op1_byte_count;
            if (r.cls.fmt == FMT_SS2)
            begin
                r.op1_byte_count = {5'h00, ins[39:36]} + 9'h001;
                r.op2_byte_count = {5'h00, ins[35:32]} + 9'h001;
            end
            r.op1_ea = ea1;
            r.op2_ea = ea2;
            r.next_addr = a + 24'h000006;
        end
        return r;
    endfunction

    // called just after a rising edge; returns one edge after the result
    task automatic run(input logic [47:0] ins, input logic [23:0] a,
                       output sfd_result_t got);
        logic r;
        int   n;
        r = 1'b0;
        n = 0;
        instr_valid <= 1'b1;
        instr <= ins;
        instr_addr <= a;
        while (!r && n < 8)
        begin
            @(negedge clk);
            r = instr_ready;
            @(posedge clk);
            n++;
        end
        instr_valid <= 1'b0;
        instr <= ~ins;
        @(negedge clk);
        check({instr_ready, dec_valid}, 2'b00);
        check({op1_base_reg, op2_base_reg}, {ins[31:28], ins[15:12]});
        @(negedge clk);
        check({instr_ready, dec_valid}, 2'b11);
        got = dec_result;
        @(posedge clk);
    endtask

    // ----
    // scenarios
    // ----
    localparam logic [7:0] SI_OPS [11] = '{8'h40, 8'h41, 8'h42, 8'h43,
        8'h44, 8'h45, 8'h46, 8'h48, 8'h49, 8'h4a, 8'h4c};

    task automatic t_si_group();
        sfd_result_t g;
        logic [47:0] ins;
        logic [23:0] a;
        for (int i = 0; i < 11; i++)
        begin
            ins = {SI_OPS[i], 8'hc3 ^ 8'(i), 4'(i + 2), 12'h800 + 12'(i),
                   16'hbeef};
            a = 24'h001000 + 24'(4 * i);
            run(ins, a, g);
            check(g, exp_of(ins, a));
        end
    endtask

    task automatic t_ss_group(input logic [7:0] base_op);
        sfd_result_t g;
        sfd_result_t e;
        logic [47:0] ins;
        logic [7:0]  len;
        logic [23:0] a;
        for (int i = 0; i < 9; i++)
        begin
            len = (i == 0) ? 8'h00 : (i == 8) ? 8'hff : 8'(i * 29);
            ins = {base_op + 8'(i), len, 4'(i), 12'hfff - 12'(i),
                   4'(15 - i), 12'(i * 273)};
            a = 24'h002000 + 24'(6 * i);
            run(ins, a, g);
            e = exp_of(ins, a);
            check(g, e);
            check({g.op1_ea, g.op2_ea}, {e.op1_ea, e.op2_ea});
            check(g.op1_byte_count, e.op1_byte_count);
        end
    endtask

    task automatic t_invalid();
        sfd_result_t g;
        logic [7:0]  bad [6];
        bad = '{8'h00, 8'h47, 8'h4b, 8'h69, 8'h79, 8'hff};
        for (int i = 0; i < 6; i++)
        begin
            run({bad[i], 40'h12345_67890}, 24'h003000, g);
            check({g.cls.fmt, g.cls.priv, g.cls.invalid, g.op1_byte_count,
                   g.op2_byte_count, g.next_addr},
                  {FMT_NONE, 2'b01, 18'h0, 24'h003000});
        end
    endtask

    task automatic t_wrap_odd();
        sfd_result_t g;
        logic [47:0] ins;
        // odd start and base 15 push both sums past the address width
        ins = {`OPC_IMMEDIATE_OR, 8'h5a, 4'hf, 12'h001, 16'h0000};
        run(ins, 24'hfffffd, g);
        check(g, exp_of(ins, 24'hfffffd));
        ins = {`OPC_CHAR_MOVE, 8'h10, 4'hf, 12'hfff, 4'hf, 12'h100};
        run(ins, 24'hfffffa, g);
        check(g, exp_of(ins, 24'hfffffa));
    endtask

    // ----
    // clock, reset, sequence, watchdog
    // ----
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        errors = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr = '0;
        instr_addr = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_si_group();
        t_ss_group(`OPC_CHAR_CMP_LOG);
        t_ss_group(`OPC_DECIMAL_ADD);
        t_invalid();
        t_wrap_odd();
        complete_run();
    end

    initial
    begin
        #(4 * 5000);
        errors++;
        complete_run();
    end
endmodule // sfd_decoder_test
